// ### tb/cip_intc_properties.sv
// Purpose: Port-level checks of the interrupt priority front end.
// Assumes: One clock; nrst_in low disables every check.
// Notes: Bound into every instance of cip_intc_core.
`timescale 1ns/1ps
`default_nettype none

module cip_intc_props
  import cip_pkg::*;
#(
  parameter logic [31:0] RESET_VECTOR = RESET_VECTOR_DEFAULT
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic reset_req_n_in,
  input wire logic branch_delay_in,
  input wire logic interrupt_acknowledge_out,
  input wire logic [3:0] serviced_number_out,
  input wire logic fetch_redirect_out,
  input wire logic [31:0] fetch_addr_out,
  input wire logic abort_out
);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire ack = interrupt_acknowledge_out;
  wire [3:0] num = serviced_number_out;

  a_ack_redirect: assert property (ack |-> fetch_redirect_out)
    else $error("acknowledge without fetch redirect");
  a_num_legal: assert property (ack |-> num != 4'h2 && num != 4'h3)
    else $error("serviced number in reserved slot");
  a_vector_slot: assert property (ack && num != NUM_RESET
    |-> fetch_addr_out[9:0] == {1'b0, num, SLOT_PAD})
    else $error("service address slot wrong");
  a_reset_vector: assert property (ack && num == NUM_RESET
    |-> fetch_addr_out == RESET_VECTOR)
    else $error("reset service address not fixed");
  a_abort_follow: assert property (
    !reset_req_n_in [*4] |-> abort_out)
    else $error("abort missing during reset request");
  a_reset_first: assert property (ack && num != NUM_RESET
    |-> $past(reset_req_n_in, 3))
    else $error("other take while reset pending");
  a_branch_defer: assert property (branch_delay_in
    |=> !(ack && num != NUM_RESET))
    else $error("take inside branch delay slots");
  a_gie_cleared: assert property (ack && num >= LINE_LO
    |=> !(ack && num >= LINE_LO))
    else $error("maskable take with global enable cleared");
  a_nonmaskable_enable_bit_cleared: assert property (ack && num == NUM_NMI
    |=> !(ack && num == NUM_NMI))
    else $error("second nonmaskable take");

  c_reset: cover property (ack && num == NUM_RESET);
  c_nmi: cover property (ack && num == NUM_NMI);
  c_line: cover property (ack && num >= LINE_LO);
endmodule // cip_intc_props

bind cip_intc_core cip_intc_props #(
  .RESET_VECTOR(RESET_VECTOR)
) props_inst (
  .clk_in(clk_in),
  .nrst_in(nrst_in),
  .reset_req_n_in(reset_req_n_in),
  .branch_delay_in(branch_delay_in),
  .interrupt_acknowledge_out(interrupt_acknowledge_out),
  .serviced_number_out(serviced_number_out),
  .fetch_redirect_out(fetch_redirect_out),
  .fetch_addr_out(fetch_addr_out),
  .abort_out(abort_out)
);

`default_nettype wire

// ### tb/cip_src_model.sv
// Purpose: Peripherals and pins that raise interrupt requests.
// Assumes: Requests are driven just after a rising clock edge.
// Notes: Nonmaskable and line requests drop by themselves after four cycles.
`timescale 1ns/1ps
`default_nettype none

module cip_src_model
  import cip_pkg::*;
(
  input wire logic clk_in,
  output logic reset_req_n_out,
  output logic nmi_out,
  output logic [LINE_COUNT-1:0] lines_out
);
  int age = 0;

  initial begin
    reset_req_n_out = 1'b1;
    nmi_out = 1'b0;
    lines_out = '0;
  end

  // Four cycles outlast the two-stage synchroniser, so no edge is lost.
  always @(posedge clk_in) begin
    age <= (nmi_out || lines_out != '0) ? age + 1 : 0;
    if (age == 3) begin
      nmi_out <= 1'b0;
      lines_out <= '0;
    end
  end

  task automatic raise(input logic nmi, input logic [LINE_COUNT-1:0] l);
    @(posedge clk_in);
    nmi_out <= nmi;
    lines_out <= l;
  endtask

  task automatic hold_reset();
    @(posedge clk_in);
    reset_req_n_out <= 1'b0;
    repeat (RESET_HOLD_CYCLES) @(posedge clk_in);
    reset_req_n_out <= 1'b1;
  endtask
endmodule // cip_src_model

`default_nettype wire

// ### tb/tb_top.sv
// Purpose: Self-checking bench of the interrupt priority front end.
// Assumes: 50 MHz clock; AXI4-Lite master in this module.
// Notes: Takes are captured by a monitor so none is missed during bus work.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import cip_pkg::*;
;
  localparam logic [31:0] RV = 32'h0000_3C00;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic reset_req_n_in;
  logic nmi_in;
  logic [LINE_COUNT-1:0] maskable_request_lines_in;
  logic branch_delay_in = 1'b0;
  logic [31:0] return_addr_in = 32'h0000_1234;
  logic irp_return_in = 1'b0;
  logic nrp_return_in = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic s_axi_wready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic interrupt_acknowledge_out;
  logic [3:0] serviced_number_out;
  logic fetch_redirect_out;
  logic [31:0] fetch_addr_out;
  logic abort_out;
  logic [3:0] gnum;
  logic [31:0] gaddr;
  logic gred;
  int acks = 0;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;

  cip_intc_core #(.RESET_VECTOR(RV)) cip_intc_core_inst (.*);
  cip_src_model cip_src_model_inst (
    .clk_in(clk_in),
    .reset_req_n_out(reset_req_n_in),
    .nmi_out(nmi_in),
    .lines_out(maskable_request_lines_in)
  );

  always #10 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  always @(posedge clk_in) begin
    if (interrupt_acknowledge_out === 1'b1) begin
      acks <= acks + 1;
      gnum <= serviced_number_out;
      gaddr <= fetch_addr_out;
      gred <= fetch_redirect_out;
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, ed);
    check(s_axi_rresp, er);
  endtask

  task automatic expect_ack(input logic [3:0] en, input logic [31:0] ea);
    for (int n = 0; n < 40 && acks == 0; n++) @(posedge clk_in);
    check(acks, 1);
    check(gnum, en);
    check(gaddr, ea);
    check(gred, 1'b1);
    acks = 0;
  endtask

  task automatic quiet(input int n);
    repeat (n) @(posedge clk_in);
    check(acks, 0);
    acks = 0;
  endtask

  task automatic strobe(input bit nrp);
    @(posedge clk_in);
    if (nrp) nrp_return_in <= 1'b1;
    else irp_return_in <= 1'b1;
    @(posedge clk_in);
    nrp_return_in <= 1'b0;
    irp_return_in <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    wr(OFF_TABLE, 32'h800, RESP_OKAY);
    wr(OFF_ENABLE, 32'h2, RESP_OKAY);
    // Branch delay slots stay open across the reset request on purpose.
    branch_delay_in <= 1'b1;
    cip_src_model_inst.hold_reset();
    check(abort_out, 1'b1);
    expect_ack(NUM_RESET, RV);
    branch_delay_in <= 1'b0;
    rd(OFF_ENABLE, 32'h1, RESP_OKAY);
    rd(OFF_TABLE, 32'h0, RESP_OKAY);
  endtask

  task automatic t_gate();
    wr(OFF_TABLE, 32'h800, RESP_OKAY);
    wr(OFF_ENABLE, 32'h280, RESP_OKAY);
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    cip_src_model_inst.raise(1'b1, 12'h028);
    quiet(10);
    rd(OFF_FLAGS, 32'h282, RESP_OKAY);
  endtask

  task automatic t_nmi();
    wr(OFF_ENABLE, 32'h282, RESP_OKAY);
    expect_ack(NUM_NMI, 32'h820);
    rd(OFF_NMI_RET, 32'h0000_1234, RESP_OKAY);
    quiet(8);
    rd(OFF_ENABLE, 32'h281, RESP_OKAY);
  endtask

  task automatic t_nest();
    strobe(1'b1);
    expect_ack(4'h7, 32'h8E0);
    rd(OFF_CTRL, 32'h2, RESP_OKAY);
    rd(OFF_RET, 32'h0000_1234, RESP_OKAY);
    wr(OFF_ENABLE, 32'h280, RESP_OKAY);
    rd(OFF_ENABLE, 32'h283, RESP_OKAY);
  endtask

  task automatic t_branch();
    @(posedge clk_in);
    branch_delay_in <= 1'b1;
    strobe(1'b0);
    quiet(8);
    branch_delay_in <= 1'b0;
    expect_ack(4'h9, 32'h920);
    wr(OFF_SET, 32'h10, RESP_OKAY);
    rd(OFF_FLAGS, 32'h10, RESP_OKAY);
    wr(OFF_CLEAR, 32'h10, RESP_OKAY);
    rd(OFF_FLAGS, 32'h0, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
  endtask

  task automatic close_out();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_gate();
    t_nmi();
    t_nest();
    t_branch();
    close_out();
  end
endmodule // tb_top

`default_nettype wire

// ### verilog/cip_edge_sync.sv
// Purpose: Two-stage synchroniser with rising-edge detection per bit.
// Assumes: Inputs may change at any time relative to clk_in.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none

module cip_edge_sync
  import cip_pkg::*;
#(
  parameter int W = SYNC_W
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out
);

  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] prev;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
    end else begin
      meta <= async_in;
      stable <= meta;
      prev <= stable;
    end
  end

  assign level_out = stable;
  assign rise_out = stable & ~prev;

endmodule // cip_edge_sync

`default_nettype wire

// ### verilog/cip_intc_core.sv
// Purpose: Interrupt priority front end of a processor core.
// Assumes: AXI4-Lite slave for control registers, one clock.
// Notes: The core reports branch delay slots and its resume address.
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module cip_intc_core
  import cip_pkg::*;
#(
  parameter logic [31:0] RESET_VECTOR = RESET_VECTOR_DEFAULT
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic reset_req_n_in,
  input wire logic nmi_in,
  input wire logic [LINE_COUNT-1:0] maskable_request_lines_in,
  input wire logic branch_delay_in,
  input wire logic [31:0] return_addr_in,
  input wire logic irp_return_in,
  input wire logic nrp_return_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic interrupt_acknowledge_out,
  output logic [3:0] serviced_number_out,
  output logic fetch_redirect_out,
  output logic [31:0] fetch_addr_out,
  output logic abort_out
);

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] sync_level;
  logic [SYNC_W-1:0] sync_rise;
  logic rst_active;
  logic in_reset;
  logic rst_release;

  // The reset request is inverted so that one edge detector serves all.
  cip_edge_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .async_in({~reset_req_n_in, nmi_in, maskable_request_lines_in}),
    .level_out(sync_level),
    .rise_out(sync_rise)
  );

  assign rst_active = sync_level[SYNC_RST];
  assign rst_release = in_reset & ~rst_active;

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  logic global_enable_bit;
  logic previous_global_enable_bit;
  logic nonmaskable_enable_bit;
  logic [LINE_HI:LINE_LO] line_enable_bit;
  logic [FLAG_W-1:0] pending_flag_register;
  logic [31:0] maskable_return_pointer;
  logic [31:0] nmi_return_pointer;
  logic [BASE_W-1:0] vector_table_base_field;
  logic reset_short;
  logic [3:0] hold_cnt;

  // ---------------------------------------------------------------
  // Bus write path
  // ---------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic wr_mapped;
  logic [31:0] rd_val;
  logic rd_mapped;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign wr_mapped = (wr_addr <= OFF_TABLE) && (wr_addr[1:0] == 2'h0);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_held <= 1'b0;
      wr_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      w_held <= 1'b0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = wr_fire && (wr_addr == off);
  endfunction

  // ---------------------------------------------------------------
  // Register views
  // ---------------------------------------------------------------
  logic [31:0] ctrl_view;
  logic [31:0] enable_view;
  logic [31:0] ctrl_new;
  logic [31:0] enable_new;
  logic [31:0] ret_new;
  logic [31:0] nmi_ret_new;
  logic [31:0] table_new;
  logic pick_valid;
  logic [3:0] pick_num;
  logic [FLAG_W-1:0] cand;

  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[CTRL_GIE] = global_enable_bit;
    ctrl_view[CTRL_PREVIOUS_GLOBAL_ENABLE_BIT] = previous_global_enable_bit;
    ctrl_view[CTRL_SHORT] = reset_short;
    enable_view = 32'h0000_0000;
    enable_view[NUM_RESET] = 1'b1;
    enable_view[EN_NONMASKABLE_ENABLE_BIT] = nonmaskable_enable_bit;
    enable_view[LINE_HI:LINE_LO] = line_enable_bit;
  end

  assign ctrl_new = cip_merge(ctrl_view, wr_data, wr_strb);
  assign enable_new = cip_merge(enable_view, wr_data, wr_strb);
  assign ret_new = cip_merge(maskable_return_pointer, wr_data, wr_strb);
  assign nmi_ret_new = cip_merge(nmi_return_pointer, wr_data, wr_strb);
  assign table_new = cip_merge({vector_table_base_field, 10'h000},
                               wr_data, wr_strb);

  // ---------------------------------------------------------------
  // Priority and take decision
  // ---------------------------------------------------------------
  logic take;
  logic take_nmi;
  logic take_mask;

  always_comb begin
    cand = '0;
    cand[NUM_NMI] = pending_flag_register[NUM_NMI] & nonmaskable_enable_bit;
    for (int k = LINE_LO; k <= LINE_HI; k++) begin
      cand[k] = pending_flag_register[k] & line_enable_bit[k] & global_enable_bit
                & nonmaskable_enable_bit;
    end
  end

  cip_pick u_pick (
    .cand_in(cand),
    .valid_out(pick_valid),
    .num_out(pick_num)
  );

  // Reset owns the core while held and in the cycle of its release.
  assign take = pick_valid & ~branch_delay_in & ~rst_active
                & ~in_reset;
  assign take_nmi = take & (pick_num == NUM_NMI);
  assign take_mask = take & (pick_num != NUM_NMI);

  // ---------------------------------------------------------------
  // Pending flags
  // ---------------------------------------------------------------
  logic [FLAG_W-1:0] next_flags;
  logic [FLAG_W-1:0] flag_set;

  always_comb begin
    flag_set = '0;
    flag_set[NUM_NMI] = sync_rise[SYNC_NMI];
    flag_set[LINE_HI:LINE_LO] = sync_rise[LINE_COUNT-1:0];
    if (wr_hit(OFF_SET)) begin
      flag_set[LINE_HI:LINE_LO] = flag_set[LINE_HI:LINE_LO]
                                  | wr_data[LINE_HI:LINE_LO];
    end
    next_flags = pending_flag_register;
    if (wr_hit(OFF_CLEAR)) begin
      next_flags[LINE_HI:LINE_LO] = next_flags[LINE_HI:LINE_LO]
                                    & ~wr_data[LINE_HI:LINE_LO];
    end
    if (take) begin
      next_flags[pick_num] = 1'b0;
    end
    // A new event in the clearing cycle survives.
    next_flags = next_flags | flag_set;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pending_flag_register <= '0;
    end else if (rst_active) begin
      pending_flag_register <= '0;
    end else begin
      pending_flag_register <= next_flags;
    end
  end

  // ---------------------------------------------------------------
  // Global, nonmaskable and line enables
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      global_enable_bit <= 1'b0;
      previous_global_enable_bit <= 1'b0;
    end else if (rst_active) begin
      global_enable_bit <= 1'b0;
      previous_global_enable_bit <= 1'b0;
    end else if (take_mask) begin
      previous_global_enable_bit <= global_enable_bit;
      global_enable_bit <= 1'b0;
    end else if (irp_return_in) begin
      global_enable_bit <= previous_global_enable_bit;
    end else if (wr_hit(OFF_CTRL)) begin
      global_enable_bit <= ctrl_new[CTRL_GIE];
      previous_global_enable_bit <= ctrl_new[CTRL_PREVIOUS_GLOBAL_ENABLE_BIT];
    end
  end

  // The nonmaskable clear on take wins over a software set in that cycle,
  // so a second nonmaskable event can never slip in.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nonmaskable_enable_bit <= 1'b0;
    end else if (rst_active) begin
      nonmaskable_enable_bit <= 1'b0;
    end else if (take_nmi) begin
      nonmaskable_enable_bit <= 1'b0;
    end else if (nrp_return_in) begin
      nonmaskable_enable_bit <= 1'b1;
    end else if (wr_hit(OFF_ENABLE) && enable_new[EN_NONMASKABLE_ENABLE_BIT]) begin
      nonmaskable_enable_bit <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      line_enable_bit <= '0;
    end else if (rst_active) begin
      line_enable_bit <= '0;
    end else if (wr_hit(OFF_ENABLE)) begin
      line_enable_bit <= enable_new[LINE_HI:LINE_LO];
    end
  end

  // ---------------------------------------------------------------
  // Return pointers and table base
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      maskable_return_pointer <= 32'h0000_0000;
    end else if (rst_active) begin
      maskable_return_pointer <= 32'h0000_0000;
    end else if (take_mask) begin
      maskable_return_pointer <= return_addr_in;
    end else if (wr_hit(OFF_RET)) begin
      maskable_return_pointer <= ret_new;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nmi_return_pointer <= 32'h0000_0000;
    end else if (rst_active) begin
      nmi_return_pointer <= 32'h0000_0000;
    end else if (take_nmi) begin
      nmi_return_pointer <= return_addr_in;
    end else if (wr_hit(OFF_NMI_RET)) begin
      nmi_return_pointer <= nmi_ret_new;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vector_table_base_field <= '0;
    end else if (rst_active) begin
      vector_table_base_field <= '0;
    end else if (wr_hit(OFF_TABLE)) begin
      vector_table_base_field <= table_new[31:BASE_LSB];
    end
  end

  // ---------------------------------------------------------------
  // Reset request tracking
  // ---------------------------------------------------------------
  // A short reset is still honoured; the flag only tells software.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_reset <= 1'b0;
      hold_cnt <= 4'h0;
      reset_short <= 1'b0;
    end else begin
      in_reset <= rst_active;
      if (rst_active) begin
        if (hold_cnt != RESET_HOLD_CYCLES) begin
          hold_cnt <= hold_cnt + 4'h1;
        end
      end else begin
        hold_cnt <= 4'h0;
      end
      if (rst_release) begin
        reset_short <= (hold_cnt < RESET_HOLD_CYCLES);
      end
    end
  end

  // ---------------------------------------------------------------
  // Processing outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      abort_out <= 1'b0;
    end else begin
      abort_out <= rst_active;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      interrupt_acknowledge_out <= 1'b0;
      fetch_redirect_out <= 1'b0;
      serviced_number_out <= NUM_RESET;
      fetch_addr_out <= 32'h0000_0000;
    end else begin
      interrupt_acknowledge_out <= 1'b0;
      fetch_redirect_out <= 1'b0;
      if (rst_release) begin
        interrupt_acknowledge_out <= 1'b1;
        fetch_redirect_out <= 1'b1;
        serviced_number_out <= NUM_RESET;
        fetch_addr_out <= RESET_VECTOR;
      end else if (take) begin
        interrupt_acknowledge_out <= 1'b1;
        fetch_redirect_out <= 1'b1;
        serviced_number_out <= pick_num;
        fetch_addr_out <= cip_vector(vector_table_base_field,
                                     pick_num);
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus read path
  // ---------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_mapped = 1'b1;
    unique case (s_axi_araddr)
      OFF_CTRL: rd_val = ctrl_view;
      OFF_ENABLE: rd_val = enable_view;
      OFF_FLAGS: rd_val = {16'h0000, pending_flag_register};
      OFF_SET: rd_val = 32'h0000_0000;
      OFF_CLEAR: rd_val = 32'h0000_0000;
      OFF_RET: rd_val = maskable_return_pointer;
      OFF_NMI_RET: rd_val = nmi_return_pointer;
      OFF_TABLE: rd_val = pick_valid
        ? cip_vector(vector_table_base_field, pick_num)
        : {vector_table_base_field, 10'h000};
      default: rd_mapped = 1'b0;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // cip_intc_core

`default_nettype wire

// ### verilog/cip_pick.sv
// Purpose: Fixed-priority picker, lowest flag position wins.
// Assumes: Candidate bits are already qualified by their enables.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none

module cip_pick
  import cip_pkg::*;
(
  input wire logic [FLAG_W-1:0] cand_in,
  output logic valid_out,
  output logic [3:0] num_out
);

  always_comb begin
    valid_out = 1'b0;
    num_out = NUM_RESET;
    for (int i = FLAG_W - 1; i >= 0; i--) begin
      if (cand_in[i]) begin
        valid_out = 1'b1;
        num_out = 4'(i);
      end
    end
  end

endmodule // cip_pick

`default_nettype wire

// ### verilog/cip_pkg.sv
// Purpose: Shared constants and helpers of the interrupt priority front end.
// Assumes: 32-bit AXI4-Lite register words at byte offsets below.
// Notes: Flag positions 0 (reset), 1 (nonmaskable), 4 to 15 (maskable).
`default_nettype none

package cip_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ENABLE = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_SET = 8'h0C;
  localparam logic [7:0] OFF_CLEAR = 8'h10;
  localparam logic [7:0] OFF_RET = 8'h14;
  localparam logic [7:0] OFF_NMI_RET = 8'h18;
  localparam logic [7:0] OFF_TABLE = 8'h1C;

  // ---------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------
  localparam int CTRL_GIE = 0;
  localparam int CTRL_PREVIOUS_GLOBAL_ENABLE_BIT = 1;
  localparam int CTRL_SHORT = 2;
  localparam int EN_NONMASKABLE_ENABLE_BIT = 1;
  localparam int LINE_LO = 4;
  localparam int LINE_HI = 15;
  localparam int LINE_COUNT = 12;
  localparam int FLAG_W = 16;
  localparam int SYNC_W = 14;
  localparam int SYNC_RST = 13;
  localparam int SYNC_NMI = 12;
  localparam int BASE_LSB = 10;
  localparam int BASE_W = 22;
  localparam logic [3:0] NUM_RESET = 4'h0;
  localparam logic [3:0] NUM_NMI = 4'h1;
  localparam logic [4:0] SLOT_PAD = 5'h00;
  localparam logic [3:0] RESET_HOLD_CYCLES = 4'hA;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RESET_VECTOR_DEFAULT = 32'h0000_0000;

  // Service packets are 20h bytes apart, so the slot number sits at bit 5.
  function automatic logic [31:0] cip_vector(input logic [BASE_W-1:0] base,
                                             input logic [3:0] num);
    cip_vector = {base, 1'b0, num, SLOT_PAD};
  endfunction

  function automatic logic [31:0] cip_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    cip_merge = (old_v & ~m) | (new_v & m);
  endfunction

endpackage : cip_pkg

`default_nettype wire
